/* File: rtl/current_dac_update_control.sv */
// register file and update scheduling for the current output converter
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module current_dac_update_control (
	// clock and reset
	input  wire logic                                  CLK,
	input  wire logic                                  RST_N,
	// ahb-lite slave
	input  wire logic                                  HSEL,
	input  wire logic [31:0]                           HADDR,
	input  wire logic [1:0]                            HTRANS,
	input  wire logic                                  HWRITE,
	input  wire logic [2:0]                            HSIZE,
	input  wire logic                                  HREADY,
	input  wire logic [31:0]                           HWDATA,
	output logic      [31:0]                           HRDATA,
	output logic                                       HREADYOUT,
	output logic                                       HRESP,
	// update events
	input  wire logic [idac_ctrl_pkg::TIMER_COUNT-1:0] TIMER_OVERFLOW,
	input  wire logic                                  EXTERNAL_CONVERT_STROBE,
	// converter side
	output logic      [idac_ctrl_pkg::WORD_W-1:0]      CONVERTER_WORD,
	output logic                                       CONVERTER_ENABLE,
	output logic      [1:0]                            FULL_SCALE_SELECT,
	output logic                                       UPDATE_PULSE
);
	logic [7:0]                            data_high;
	logic [1:0]                            data_low;
	logic                                  enable;
	logic [2:0]                            source;
	logic [1:0]                            full_scale;
	logic                                  ph_write;
	logic [9:0]                            ph_addr;
	logic                                  high_write;
	logic                                  fire;
	logic                                  rise;
	logic                                  fall;
	logic [idac_ctrl_pkg::TIMER_COUNT-1:0] tmr_pulse;
	logic [31:0]                           next_rdata;
	logic [7:0]                            fwd_high;
	logic [1:0]                            fwd_low;
	logic                                  fwd_enable;
	logic [2:0]                            fwd_source;
	logic [1:0]                            fwd_full_scale;

	// strobe synchroniser and edge pulses
	strobe_edge_detect u_strobe (
		.CLK    (CLK),
		.RST_N  (RST_N),
		.strobe (EXTERNAL_CONVERT_STROBE),
		.rise   (rise),
		.fall   (fall)
	);

	// timer overflow pulses
	timer_pulse_shaper u_timers (
		.CLK      (CLK),
		.RST_N    (RST_N),
		.overflow (TIMER_OVERFLOW),
		.pulse    (tmr_pulse)
	);

	// decode of a register read value, also used by the read mux
	function automatic logic [31:0] read_value(input logic [9:0] a, input logic [7:0] hi, input logic [1:0] lo,
		input logic en, input logic [2:0] src, input logic [1:0] fs);
		logic [31:0] v;
		v = idac_ctrl_pkg::READ_ZERO;
		unique case (a)
			idac_ctrl_pkg::ADDR_DATA_HIGH: v[7:0] = hi;
			idac_ctrl_pkg::ADDR_DATA_LOW:  v[7:6] = lo;
			idac_ctrl_pkg::ADDR_CONTROL:   v[7:0] = {en, src, 2'b00, fs};
			default:                       v = idac_ctrl_pkg::READ_ZERO;
		endcase
		return v;
	endfunction : read_value

	// address phase capture; the slave never inserts wait states
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ph_write <= 1'b0;
			ph_addr  <= '0;
		end else if (HREADY) begin
			ph_write <= HSEL & HWRITE & (HTRANS == idac_ctrl_pkg::HTRANS_NONSEQ)
				& (HSIZE == idac_ctrl_pkg::HSIZE_WORD);
			ph_addr  <= HADDR[9:0];
		end
	end

	// read data registered at the address phase so hrdata comes from a flop;
	// a write still in its data phase is forwarded, so a read right behind it sees the new value
	always_comb begin
		fwd_high       = data_high;
		fwd_low        = data_low;
		fwd_enable     = enable;
		fwd_source     = source;
		fwd_full_scale = full_scale;
		if (ph_write && ph_addr == idac_ctrl_pkg::ADDR_DATA_HIGH) begin
			fwd_high = HWDATA[7:0];
		end
		if (ph_write && ph_addr == idac_ctrl_pkg::ADDR_DATA_LOW) begin
			fwd_low = HWDATA[idac_ctrl_pkg::LOW_KEEP_HI:idac_ctrl_pkg::LOW_KEEP_LO];
		end
		if (ph_write && ph_addr == idac_ctrl_pkg::ADDR_CONTROL) begin
			fwd_enable     = HWDATA[idac_ctrl_pkg::CTL_EN_BIT];
			fwd_source     = HWDATA[idac_ctrl_pkg::CTL_SRC_HI:idac_ctrl_pkg::CTL_SRC_LO];
			fwd_full_scale = HWDATA[idac_ctrl_pkg::CTL_FS_HI:idac_ctrl_pkg::CTL_FS_LO];
		end
		next_rdata = read_value(HADDR[9:0], fwd_high, fwd_low, fwd_enable, fwd_source, fwd_full_scale);
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			HRDATA    <= idac_ctrl_pkg::READ_ZERO;
			HREADYOUT <= 1'b1;
			HRESP     <= idac_ctrl_pkg::HRESP_OKAY;
		end else begin
			if (HREADY && HSEL && !HWRITE && HTRANS == idac_ctrl_pkg::HTRANS_NONSEQ) begin
				HRDATA <= next_rdata;
			end
			HREADYOUT <= 1'b1;
			HRESP     <= idac_ctrl_pkg::HRESP_OKAY;
		end
	end

	assign high_write = ph_write && (ph_addr == idac_ctrl_pkg::ADDR_DATA_HIGH);

	// control register; bits three and two have no storage
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			enable     <= idac_ctrl_pkg::RST_ENABLE;
			source     <= idac_ctrl_pkg::RST_SOURCE;
			full_scale <= idac_ctrl_pkg::RST_FULL_SCALE;
		end else if (ph_write && ph_addr == idac_ctrl_pkg::ADDR_CONTROL) begin
			enable     <= HWDATA[idac_ctrl_pkg::CTL_EN_BIT];
			source     <= HWDATA[idac_ctrl_pkg::CTL_SRC_HI:idac_ctrl_pkg::CTL_SRC_LO];
			full_scale <= HWDATA[idac_ctrl_pkg::CTL_FS_HI:idac_ctrl_pkg::CTL_FS_LO];
		end
	end

	// held data registers; only bits seven and six of the low byte are kept
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			data_high <= idac_ctrl_pkg::RST_DATA;
			data_low  <= '0;
		end else if (ph_write) begin
			if (ph_addr == idac_ctrl_pkg::ADDR_DATA_HIGH) begin
				data_high <= HWDATA[7:0];
			end
			if (ph_addr == idac_ctrl_pkg::ADDR_DATA_LOW) begin
				data_low <= HWDATA[idac_ctrl_pkg::LOW_KEEP_HI:idac_ctrl_pkg::LOW_KEEP_LO];
			end
		end
	end

	// update event selection
	always_comb begin
		unique case (idac_ctrl_pkg::update_source_t'(source))
			idac_ctrl_pkg::SRC_TIMER0: fire = tmr_pulse[0];
			idac_ctrl_pkg::SRC_TIMER1: fire = tmr_pulse[1];
			idac_ctrl_pkg::SRC_TIMER2: fire = tmr_pulse[2];
			idac_ctrl_pkg::SRC_TIMER3: fire = tmr_pulse[3];
			idac_ctrl_pkg::SRC_RISE:   fire = rise;
			idac_ctrl_pkg::SRC_FALL:   fire = fall;
			idac_ctrl_pkg::SRC_ANY:    fire = rise | fall;
			idac_ctrl_pkg::SRC_WRITE:  fire = high_write;
		endcase
	end

	// converter input latch; in write mode the high write latches its own new byte,
	// in every other mode the held bytes are copied, even if a high write lands on the event
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			CONVERTER_WORD <= '0;
			UPDATE_PULSE   <= 1'b0;
		end else begin
			UPDATE_PULSE <= fire;
			if (fire) begin
				if (idac_ctrl_pkg::update_source_t'(source) == idac_ctrl_pkg::SRC_WRITE) begin
					CONVERTER_WORD <= {HWDATA[7:0], data_low};
				end else begin
					CONVERTER_WORD <= {data_high, data_low};
				end
			end
		end
	end

	// converter control outputs straight from flops
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			CONVERTER_ENABLE  <= idac_ctrl_pkg::RST_ENABLE;
			FULL_SCALE_SELECT <= idac_ctrl_pkg::RST_FULL_SCALE;
		end else begin
			CONVERTER_ENABLE  <= enable;
			FULL_SCALE_SELECT <= full_scale[1] ? idac_ctrl_pkg::FS_TWO_MA : full_scale;
		end
	end

	// bus response checks
	bus_okay_a: assert property (@(posedge CLK) disable iff (!RST_N)
		1'b1 |-> HREADYOUT && HRESP == idac_ctrl_pkg::HRESP_OKAY)
		else $error("bus response not ready and okay");

	// register read and store checks
	high_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(HREADY && HSEL && !HWRITE && HTRANS == idac_ctrl_pkg::HTRANS_NONSEQ
		&& HADDR[9:0] == idac_ctrl_pkg::ADDR_DATA_HIGH) |=> HRDATA == {24'h000000, data_high})
		else $error("high data read differs from stored byte");
	low_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(HREADY && HSEL && !HWRITE && HTRANS == idac_ctrl_pkg::HTRANS_NONSEQ
		&& HADDR[9:0] == idac_ctrl_pkg::ADDR_DATA_LOW) |=> HRDATA[7:6] == data_low)
		else $error("low data read differs from stored bits");
	ctl_unused_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(HREADY && HSEL && !HWRITE && HTRANS == idac_ctrl_pkg::HTRANS_NONSEQ
		&& HADDR[9:0] == idac_ctrl_pkg::ADDR_CONTROL) |=> HRDATA[3:2] == 2'b00 && HRDATA[31:8] == '0)
		else $error("control unused bits not zero");
	low_unused_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(HREADY && HSEL && !HWRITE && HTRANS == idac_ctrl_pkg::HTRANS_NONSEQ
		&& HADDR[9:0] == idac_ctrl_pkg::ADDR_DATA_LOW) |=> HRDATA[5:0] == 6'h00)
		else $error("low data unused bits not zero");
	ctl_store_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(ph_write && ph_addr == idac_ctrl_pkg::ADDR_CONTROL) |=> enable == $past(HWDATA[idac_ctrl_pkg::CTL_EN_BIT])
		&& full_scale == $past(HWDATA[idac_ctrl_pkg::CTL_FS_HI:idac_ctrl_pkg::CTL_FS_LO]))
		else $error("control write not stored");

	// update scheduling checks
	word_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
		!UPDATE_PULSE |-> $stable(CONVERTER_WORD))
		else $error("converter word changed without update");
	write_update_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(source == idac_ctrl_pkg::SRC_WRITE && high_write)
		|=> UPDATE_PULSE && CONVERTER_WORD == {$past(HWDATA[7:0]), data_low})
		else $error("high write did not update output");
	write_only_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(source == idac_ctrl_pkg::SRC_WRITE && !high_write) |=> !UPDATE_PULSE)
		else $error("write mode updated without high write");
	low_held_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(ph_write && ph_addr == idac_ctrl_pkg::ADDR_DATA_LOW && !fire) |=> $stable(CONVERTER_WORD))
		else $error("low write reached output");
	rise_update_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(source == idac_ctrl_pkg::SRC_RISE && rise)
		|=> UPDATE_PULSE && CONVERTER_WORD == {$past(data_high), $past(data_low)})
		else $error("rising strobe did not copy word");
	fall_update_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(source == idac_ctrl_pkg::SRC_FALL && fall)
		|=> UPDATE_PULSE && CONVERTER_WORD == {$past(data_high), $past(data_low)})
		else $error("falling strobe did not copy word");
	any_update_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(source == idac_ctrl_pkg::SRC_ANY && (rise || fall))
		|=> UPDATE_PULSE && CONVERTER_WORD == {$past(data_high), $past(data_low)})
		else $error("strobe edge did not copy word");
	rise_only_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(source == idac_ctrl_pkg::SRC_RISE && fall) |=> !UPDATE_PULSE)
		else $error("falling strobe updated in rising mode");
	fall_only_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(source == idac_ctrl_pkg::SRC_FALL && rise) |=> !UPDATE_PULSE)
		else $error("rising strobe updated in falling mode");
	timer_update_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(source == idac_ctrl_pkg::SRC_TIMER2 && $rose(TIMER_OVERFLOW[2])) |=> UPDATE_PULSE)
		else $error("timer two overflow did not update");
	tmr_select_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(!source[2] && tmr_pulse[source[1:0]]) |=> UPDATE_PULSE)
		else $error("selected timer overflow did not update");
	timer_ignore_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(source == idac_ctrl_pkg::SRC_TIMER0 && !$rose(TIMER_OVERFLOW[0])) |=> !UPDATE_PULSE)
		else $error("timer zero mode updated without its overflow");
	timer_word_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(source == idac_ctrl_pkg::SRC_TIMER0 && $rose(TIMER_OVERFLOW[0]))
		|=> CONVERTER_WORD == {$past(data_high), $past(data_low)})
		else $error("timer overflow did not copy held word");

	// strobe synchroniser checks
	edge_pulse_a: assert property (@(posedge CLK) disable iff (!RST_N)
		rise |=> !rise)
		else $error("strobe edge pulse longer than one cycle");
	strobe_lag_a: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(EXTERNAL_CONVERT_STROBE) ##1 EXTERNAL_CONVERT_STROBE ##1 EXTERNAL_CONVERT_STROBE |-> rise)
		else $error("strobe edge not seen after sync");

	// converter control output checks
	fs_map_a: assert property (@(posedge CLK) disable iff (!RST_N)
		full_scale[1] |=> FULL_SCALE_SELECT == idac_ctrl_pkg::FS_TWO_MA)
		else $error("full scale 1x not two milliamp");
	fs_low_a: assert property (@(posedge CLK) disable iff (!RST_N)
		!full_scale[1] |=> FULL_SCALE_SELECT == $past(full_scale))
		else $error("full scale code not passed through");
	enable_follow_a: assert property (@(posedge CLK) disable iff (!RST_N)
		1'b1 |=> CONVERTER_ENABLE == $past(enable))
		else $error("enable output not following bit");

	// main scenarios
	write_mode_c: cover property (@(posedge CLK) disable iff (!RST_N) source == idac_ctrl_pkg::SRC_WRITE && high_write);
	timer_mode_c: cover property (@(posedge CLK) disable iff (!RST_N) source == idac_ctrl_pkg::SRC_TIMER0 && fire);
	rise_mode_c:  cover property (@(posedge CLK) disable iff (!RST_N) source == idac_ctrl_pkg::SRC_RISE && rise);
	fall_mode_c:  cover property (@(posedge CLK) disable iff (!RST_N) source == idac_ctrl_pkg::SRC_FALL && fall);
	any_edge_c:   cover property (@(posedge CLK) disable iff (!RST_N) source == idac_ctrl_pkg::SRC_ANY && fall);
endmodule : current_dac_update_control

/* File: rtl/idac_ctrl_pkg.sv */
// shared constants for the current dac update control block
package idac_ctrl_pkg;
	// register byte offsets; the index is kept and the address is four times it
	localparam logic [7:0]  IDX_DATA_LOW  = 8'h96;
	localparam logic [7:0]  IDX_DATA_HIGH = 8'h97;
	localparam logic [7:0]  IDX_CONTROL   = 8'hB9;
	localparam int          ADDR_W        = 10;
	localparam logic [9:0]  ADDR_DATA_LOW  = {IDX_DATA_LOW, 2'b00};
	localparam logic [9:0]  ADDR_DATA_HIGH = {IDX_DATA_HIGH, 2'b00};
	localparam logic [9:0]  ADDR_CONTROL   = {IDX_CONTROL, 2'b00};
	// control field layout
	localparam int          CTL_EN_BIT     = 7;
	localparam int          CTL_SRC_HI     = 6;
	localparam int          CTL_SRC_LO     = 4;
	localparam int          CTL_FS_HI      = 1;
	localparam int          CTL_FS_LO      = 0;
	localparam int          LOW_KEEP_HI    = 7;
	localparam int          LOW_KEEP_LO    = 6;
	localparam int          WORD_W         = 10;
	// reset values
	localparam logic        RST_ENABLE     = 1'b0;
	localparam logic [2:0]  RST_SOURCE     = 3'h7;
	localparam logic [1:0]  RST_FULL_SCALE = 2'h2;
	localparam logic [7:0]  RST_DATA       = 8'h00;
	// full-scale codes
	localparam logic [1:0]  FS_HALF_MA     = 2'h0;
	localparam logic [1:0]  FS_ONE_MA      = 2'h1;
	localparam logic [1:0]  FS_TWO_MA      = 2'h2;
	// update source codes
	typedef enum logic [2:0] {
		SRC_TIMER0  = 3'h0,
		SRC_TIMER1  = 3'h1,
		SRC_TIMER2  = 3'h2,
		SRC_TIMER3  = 3'h3,
		SRC_RISE    = 3'h4,
		SRC_FALL    = 3'h5,
		SRC_ANY     = 3'h6,
		SRC_WRITE   = 3'h7
	} update_source_t;
	localparam int          TIMER_COUNT    = 4;
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
	localparam logic [2:0]  HSIZE_WORD     = 3'h2;
	localparam logic        HRESP_OKAY     = 1'b0;
	localparam logic [31:0] READ_ZERO      = 32'h0000_0000;
endpackage : idac_ctrl_pkg

/* File: rtl/strobe_edge_detect.sv */
// synchroniser and edge detector for the external convert strobe
`timescale 1ns/1ps
module strobe_edge_detect (
	// clock and reset
	input  wire logic CLK,
	input  wire logic RST_N,
	// strobe in, edge pulses out
	input  wire logic strobe,
	output logic      rise,
	output logic      fall
);
	logic sync1;
	logic sync2;
	logic prev;

	// two flops bring the strobe onto the clock, a third holds last level
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			prev  <= 1'b0;
		end else begin
			sync1 <= strobe;
			sync2 <= sync1;
			prev  <= sync2;
		end
	end

	// single-cycle edge pulses
	assign rise = sync2 & ~prev;
	assign fall = ~sync2 & prev;
endmodule : strobe_edge_detect

/* File: rtl/timer_pulse_shaper.sv */
// turns each timer overflow level into one-cycle pulses
`timescale 1ns/1ps
module timer_pulse_shaper (
	// clock and reset
	input  wire logic                                 CLK,
	input  wire logic                                 RST_N,
	// overflow flags in, pulses out
	input  wire logic [idac_ctrl_pkg::TIMER_COUNT-1:0] overflow,
	output logic      [idac_ctrl_pkg::TIMER_COUNT-1:0] pulse
);
	logic [idac_ctrl_pkg::TIMER_COUNT-1:0] last;

	// one rising-edge detector per timer
	genvar i;
	generate
		for (i = 0; i < idac_ctrl_pkg::TIMER_COUNT; i++) begin : g_tmr
			always_ff @(posedge CLK or negedge RST_N) begin
				if (!RST_N) begin
					last[i] <= 1'b0;
				end else begin
					last[i] <= overflow[i];
				end
			end
			assign pulse[i] = overflow[i] & ~last[i];
		end
	endgenerate
endmodule : timer_pulse_shaper

/* File: verif/current_dac_update_control_tb.sv */
// self-checking bench for the current dac update control block
`timescale 1ns/1ps
module current_dac_update_control_tb;
	logic        CLK;
	logic        RST_N;
	logic        HSEL;
	logic [31:0] HADDR;
	logic [1:0]  HTRANS;
	logic        HWRITE;
	logic [2:0]  HSIZE;
	wire  logic  HREADY;
	logic [31:0] HWDATA;
	logic [31:0] HRDATA;
	logic        HREADYOUT;
	logic        HRESP;
	logic [3:0]  TIMER_OVERFLOW;
	logic        EXTERNAL_CONVERT_STROBE;
	logic [9:0]  CONVERTER_WORD;
	logic        CONVERTER_ENABLE;
	logic [1:0]  FULL_SCALE_SELECT;
	logic        UPDATE_PULSE;
	logic        rd_phase;
	logic [31:0] rq[$];
	logic [31:0] wq[$];
	int          n_errors;
	int          n_checks;
	int          seed;
	logic [7:0]  lo;
	logic [7:0]  hi;
	// the single slave drives the bus ready
	assign HREADY = HREADYOUT;
	current_dac_update_control uut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADY), .HWDATA(HWDATA), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .TIMER_OVERFLOW(TIMER_OVERFLOW),
		.EXTERNAL_CONVERT_STROBE(EXTERNAL_CONVERT_STROBE), .CONVERTER_WORD(CONVERTER_WORD),
		.CONVERTER_ENABLE(CONVERTER_ENABLE), .FULL_SCALE_SELECT(FULL_SCALE_SELECT), .UPDATE_PULSE(UPDATE_PULSE));
	// clock generator, 25 ns period
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	// compare one result and count it
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	// print the counts and the verdict, then stop
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	// one single ahb-lite word transfer, address phase then data phase
	task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] wd);
		@(posedge CLK);
		HSEL <= 1'b1;
		HADDR <= {22'h000000, a};
		HTRANS <= idac_ctrl_pkg::HTRANS_NONSEQ;
		HWRITE <= w;
		HSIZE <= idac_ctrl_pkg::HSIZE_WORD;
		do @(posedge CLK); while (HREADY !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		rd_phase <= !w;
		do @(posedge CLK); while (HREADY !== 1'b1);
		rd_phase <= 1'b0;
	endtask : xfer
	// read with the expected word noted for the monitor
	task automatic rd(input logic [9:0] a, input logic [31:0] exp);
		rq.push_back(exp);
		xfer(1'b0, a, 32'($random(seed)));
	endtask : rd
	// let n edges pass and sample away from the edge
	task automatic settle(input int n);
		repeat (n) @(posedge CLK);
		@(negedge CLK);
	endtask : settle
	// load both data bytes with random values
	task automatic load_data;
		lo = 8'($random(seed));
		hi = 8'($random(seed));
		xfer(1'b1, idac_ctrl_pkg::ADDR_DATA_LOW, {24'h000000, lo});
		xfer(1'b1, idac_ctrl_pkg::ADDR_DATA_HIGH, {24'h000000, hi});
	endtask : load_data
	// monitor: read data at the end of a data phase, converter word on each update pulse
	always @(posedge CLK) begin
		if (rd_phase === 1'b1 && rq.size() > 0) begin
			cmp("read data", rq.pop_front(), HRDATA);
			cmp("bus response", 32'h2, {30'h0, HREADYOUT, HRESP});
		end
		if (UPDATE_PULSE === 1'b1) begin
			if (wq.size() == 0)
				cmp("update pulse", 32'h0, 32'h1);
			else
				cmp("converter word", wq.pop_front(), {22'h000000, CONVERTER_WORD});
		end
	end
	// watchdog far beyond the few hundred cycles of the run
	initial begin
		#(25 * 20000);
		n_errors++;
		test_done();
	end
	// main sequence
	initial begin
		n_errors = 0;
		n_checks = 0;
		seed = 32'h9500;
		RST_N = 1'b0;
		HSEL = 1'b0;
		HADDR = 32'h0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h0;
		HWDATA = 32'h0;
		rd_phase = 1'b0;
		TIMER_OVERFLOW = 4'h0;
		EXTERNAL_CONVERT_STROBE = 1'b0;
		repeat (2) @(posedge CLK);
		RST_N <= 1'b1;
		settle(0);
		cmp("full scale", 32'h2, {30'h0, FULL_SCALE_SELECT});
		cmp("enable", 32'h0, {31'h0, CONVERTER_ENABLE});
		rd(idac_ctrl_pkg::ADDR_CONTROL, 32'h72);
		rd(idac_ctrl_pkg::ADDR_DATA_HIGH, 32'h0);
		$display("test reset done");
		// write mode: low byte held until the high byte lands
		lo = 8'($random(seed)) | 8'h3F;
		hi = 8'($random(seed));
		xfer(1'b1, idac_ctrl_pkg::ADDR_DATA_LOW, {24'hFFFFFF, lo});
		settle(3);
		rd(idac_ctrl_pkg::ADDR_DATA_LOW, {24'h0, lo[7:6], 6'h00});
		wq.push_back({22'h0, hi, lo[7:6]});
		xfer(1'b1, idac_ctrl_pkg::ADDR_DATA_HIGH, {24'hFFFFFF, hi});
		settle(3);
		$display("test write update done");
		// full scale codes with enable set and junk in the unused bits
		for (int f = 0; f < 4; f++) begin
			xfer(1'b1, idac_ctrl_pkg::ADDR_CONTROL, 32'hFC | f);
			settle(2);
			cmp("full scale", (f == 3) ? 32'h2 : f, {30'h0, FULL_SCALE_SELECT});
			cmp("enable", 32'h1, {31'h0, CONVERTER_ENABLE});
			rd(idac_ctrl_pkg::ADDR_CONTROL, 32'hF0 | f);
		end
		$display("test control done");
		// timer modes: the next timer is ignored, selected one copies the held word
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, idac_ctrl_pkg::ADDR_CONTROL, 32'h2 | (i << 4));
			load_data();
			repeat (3) @(posedge CLK);
			TIMER_OVERFLOW <= 4'h1 << ((i + 1) % 4);
			repeat (2) @(posedge CLK);
			TIMER_OVERFLOW <= 4'h0;
			repeat (4) @(posedge CLK);
			wq.push_back({22'h0, hi, lo[7:6]});
			TIMER_OVERFLOW <= 4'h1 << i;
			repeat (2) @(posedge CLK);
			TIMER_OVERFLOW <= 4'h0;
			settle(4);
		end
		$display("test timer modes done");
		// strobe modes: rising, falling, either edge
		for (int m = 4; m < 7; m++) begin
			xfer(1'b1, idac_ctrl_pkg::ADDR_CONTROL, 32'h2 | (m << 4));
			load_data();
			if (m != 5)
				wq.push_back({22'h0, hi, lo[7:6]});
			EXTERNAL_CONVERT_STROBE <= 1'b1;
			repeat (6) @(posedge CLK);
			if (m != 4)
				wq.push_back({22'h0, hi, lo[7:6]});
			EXTERNAL_CONVERT_STROBE <= 1'b0;
			settle(6);
		end
		$display("test strobe modes done");
		// unmapped address: write ignored, read zero
		xfer(1'b1, 10'h100, 32'hFFFFFFFF);
		rd(10'h100, idac_ctrl_pkg::READ_ZERO);
		settle(4);
		cmp("pending updates", 32'h0, 32'(wq.size()));
		$display("test unmapped done");
		test_done();
	end
endmodule : current_dac_update_control_tb
